// *** verilog/rbsc_consts.svh ***
// constants for the reset and boot strap capture block
`ifndef RBSC_CONSTS_SVH
`define RBSC_CONSTS_SVH
`define RBSC_ADDR_PUD 4'h0
`define RBSC_ADDR_STATUS 4'h4
`define RBSC_ADDR_MODE 4'h8
`define RBSC_PUD_RESET_BIT 0
`define RBSC_PUD_BOOT_BIT 1
`define RBSC_PUD_WIDTH_BIT 2
`define RBSC_PUD_RESET_VAL 3'h0
`define RBSC_ST_RESET_BIT 0
`define RBSC_ST_BOOT_BIT 1
`define RBSC_ST_WIDE_BIT 2
`define RBSC_ST_SECURE_BIT 3
`define RBSC_ST_POR_BIT 4
`define RBSC_HOLD_CYCLES 16
`define RBSC_POR_CYCLES 32
`endif

// *** verilog/rbsc_pkg.sv ***
// types for the reset and boot strap capture block
package rbsc_pkg;
    typedef enum logic [1:0] {
        RBSC_POR   = 2'b00,
        RBSC_HELD  = 2'b01,
        RBSC_COUNT = 2'b10,
        RBSC_RUN   = 2'b11
    } rbsc_state_e;
endpackage

// *** verilog/rbsc_sync.sv ***
// two flop synchroniser for a bundle of level inputs
`timescale 1ns/1ps
module rbsc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    // first stage is read only by the second
    always_ff @(posedge clk_i)
    begin
        meta <= d_i;
        q_o <= meta;
    end
endmodule

// *** verilog/rbsc_top.sv ***
// reset combiner, reset output and boot strap capture with wishbone regs
`timescale 1ns/1ps
`include "rbsc_consts.svh"

module rbsc_top
    import rbsc_pkg::*;
#(
    parameter int HOLD_CYCLES = `RBSC_HOLD_CYCLES,
    parameter int POR_CYCLES = `RBSC_POR_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reset_pin_n_i,
    input wire logic test_reset_n_i,
    input wire logic external_boot_strap_i,
    input wire logic address_width_strap_i,
    input wire logic flash_secured_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic sys_reset_n_o,
    output logic debug_reset_n_o,
    output logic reset_output_pin_n_o,
    output logic boot_mode_bit_o,
    output logic wide_address_o,
    output logic flash_secure_mode_o,
    output logic reset_pullup_en_o,
    output logic boot_strap_pullup_en_o,
    output logic width_strap_pullup_en_o
);
    rbsc_state_e state;
    rbsc_state_e next_state;
    logic [15:0] count;
    logic [2:0] pull_up_disable_reg;
    logic [2:0] pins_s;
    logic reset_pin_s;
    logic boot_strap_s;
    logic width_strap_s;
    logic por_done;
    logic wb_hit;

    // pins treated as asynchronous board levels, so synchronise them
    rbsc_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk_i(clk_i),
        .d_i({reset_pin_n_i, external_boot_strap_i, address_width_strap_i}),
        .q_o(pins_s)
    );
    assign reset_pin_s = pins_s[2];
    assign boot_strap_s = pins_s[1];
    assign width_strap_s = pins_s[0];

    // reset sequencer: power-on, held by pin, fixed count, running
    always_comb
    begin
        next_state = state;
        unique case (state)
            RBSC_POR:
                if (por_done)
                    next_state = RBSC_HELD;
            RBSC_HELD:
                if (reset_pin_s)
                    next_state = RBSC_COUNT;
            RBSC_COUNT:
                if (!reset_pin_s)
                    next_state = RBSC_HELD;
                else if (count == 16'(HOLD_CYCLES - 1))
                    next_state = RBSC_RUN;
            RBSC_RUN:
                if (!reset_pin_s)
                    next_state = RBSC_HELD;
        endcase
    end

    // rst_i models the power-on reset source
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state <= RBSC_POR;
        else
            state <= next_state;
    end

    // one counter serves the power-on hold and the post-release hold
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count <= 16'h0000;
            por_done <= 1'b0;
        end
        else
        begin
            if (state == RBSC_POR)
            begin
                if (count == 16'(POR_CYCLES - 1))
                    por_done <= 1'b1;
                else
                    count <= count + 16'h0001;
            end
            else if (state == RBSC_COUNT)
                count <= count + 16'h0001;
            else
                count <= 16'h0000;
        end
    end

    // internal reset and its pin mirror share one flop each
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sys_reset_n_o <= 1'b0;
            reset_output_pin_n_o <= 1'b0;
        end
        else
        begin
            sys_reset_n_o <= (next_state == RBSC_RUN);
            reset_output_pin_n_o <= (next_state == RBSC_RUN);
        end
    end

    // debug logic follows power-on and test reset only, never the pin
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            debug_reset_n_o <= 1'b0;
        else
            debug_reset_n_o <= (state != RBSC_POR) && test_reset_n_i;
    end

    // straps captured on the release edge, then frozen until next reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            boot_mode_bit_o <= 1'b0;
            wide_address_o <= 1'b0;
            flash_secure_mode_o <= 1'b0;
        end
        else if (state == RBSC_HELD && reset_pin_s)
        begin
            // secured flash cannot boot externally
            boot_mode_bit_o <= boot_strap_s && !flash_secured_i;
            wide_address_o <= width_strap_s;
            flash_secure_mode_o <= flash_secured_i;
        end
    end

    // pull-up disable register, writable while the core runs
    always_ff @(posedge clk_i)
    begin
        if (rst_i || state == RBSC_POR)
            pull_up_disable_reg <= `RBSC_PUD_RESET_VAL;
        else if (wb_hit && wb_we_i && wb_sel_i[0]
                 && wb_adr_i == `RBSC_ADDR_PUD)
            pull_up_disable_reg <= wb_dat_i[2:0];
    end

    // pull-up enables are the inverse of the disable bits
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reset_pullup_en_o <= 1'b1;
            boot_strap_pullup_en_o <= 1'b1;
            width_strap_pullup_en_o <= 1'b1;
        end
        else
        begin
            reset_pullup_en_o <=
                !pull_up_disable_reg[`RBSC_PUD_RESET_BIT];
            boot_strap_pullup_en_o <=
                !pull_up_disable_reg[`RBSC_PUD_BOOT_BIT];
            width_strap_pullup_en_o <=
                !pull_up_disable_reg[`RBSC_PUD_WIDTH_BIT];
        end
    end

    // wishbone classic: one wait state, ack drops after one cycle
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_hit;
    end

    // read mux; unmapped offsets read zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (wb_hit && !wb_we_i)
        begin
            unique case (wb_adr_i)
                `RBSC_ADDR_PUD:
                    wb_dat_o <= {29'h0, pull_up_disable_reg};
                `RBSC_ADDR_STATUS:
                    wb_dat_o <= {27'h0, state == RBSC_POR, flash_secure_mode_o,
                                 wide_address_o, boot_mode_bit_o,
                                 sys_reset_n_o};
                `RBSC_ADDR_MODE:
                    wb_dat_o <= {29'h0, pins_s};
                default:
                    wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// *** tb/rbsc_chk_assertions.sv ***
// assertions for the reset and boot strap block
`timescale 1ns/1ps
module rbsc_chk #(
    parameter int HOLD_CYCLES = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reset_pin_n_i,
    input wire logic test_reset_n_i,
    input wire logic sys_reset_n_o,
    input wire logic debug_reset_n_o,
    input wire logic reset_output_pin_n_o,
    input wire logic boot_mode_bit_o,
    input wire logic wide_address_o,
    input wire logic flash_secure_mode_o,
    input wire logic reset_pullup_en_o,
    input wire logic boot_strap_pullup_en_o,
    input wire logic width_strap_pullup_en_o
);
    int hi;
    // cycles the raw pin stayed high; an upper bound on the hold
    always_ff @(posedge clk_i)
        hi <= (rst_i || !reset_pin_n_i) ? 0 : hi + 1;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_pin_low;
        !reset_pin_n_i [*2];
    endsequence
    property p_mir; reset_output_pin_n_o == sys_reset_n_o; endproperty
    a_mir: assert property (p_mir) else $error("mirror");
    property p_por; $fell(rst_i) |-> !sys_reset_n_o && !debug_reset_n_o;
    endproperty
    a_por: assert property (p_por) else $error("power on");
    property p_pon; $fell(rst_i) |-> reset_pullup_en_o &&
        boot_strap_pullup_en_o && width_strap_pullup_en_o; endproperty
    a_pon: assert property (p_pon) else $error("pull-ups");
    property p_sec; flash_secure_mode_o |-> !boot_mode_bit_o; endproperty
    a_sec: assert property (p_sec) else $error("secure boot");
    property p_hold; $rose(sys_reset_n_o) |-> hi > HOLD_CYCLES; endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_keep; sys_reset_n_o && $past(sys_reset_n_o) |->
        $stable({boot_mode_bit_o, wide_address_o, flash_secure_mode_o});
    endproperty
    a_keep: assert property (p_keep) else $error("straps");
    property p_dbg; debug_reset_n_o && test_reset_n_i ##1
        test_reset_n_i [*2] |-> debug_reset_n_o; endproperty
    a_dbg: assert property (p_dbg) else $error("debug");
    property p_pin; s_pin_low |-> ##[1:4] !sys_reset_n_o; endproperty
    a_pin: assert property (p_pin) else $error("pin reset");
endmodule
bind rbsc_top rbsc_chk #(.HOLD_CYCLES(HOLD_CYCLES)) i_rbsc_chk (.clk_i,
    .rst_i, .reset_pin_n_i, .test_reset_n_i, .sys_reset_n_o,
    .debug_reset_n_o, .reset_output_pin_n_o, .boot_mode_bit_o,
    .wide_address_o, .flash_secure_mode_o, .reset_pullup_en_o,
    .boot_strap_pullup_en_o, .width_strap_pullup_en_o);

// *** tb/rbsc_board.sv ***
// board model: reset source, boot straps and debug probe
`timescale 1ns/1ps
module rbsc_board (
    input wire logic clk_i,
    input wire logic full_i,
    input wire logic chip_i,
    input wire logic [2:0] strap_i,
    output logic reset_pin_n_o = 1'b1,
    output logic test_reset_n_o = 1'b1,
    output logic [2:0] strap_o = 3'h0
);
    // full reset drives both lines together; chip only spares debug
    always_ff @(posedge clk_i)
    begin
        reset_pin_n_o <= !(full_i || chip_i);
        test_reset_n_o <= !full_i;
        strap_o <= strap_i;
    end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the reset and boot strap block
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 0, rst_i = 1, full = 0, chip = 0, cyc = 0, we = 0;
    logic pin_n, trst_n, ack, sys_n, dbg_n, reset_output_pin_n, boot, wide, sec;
    logic pr, pb, pw;
    logic [2:0] st = 0, sp, s, e = 0;
    logic [3:0] sel = 0, adr = 0;
    logic [31:0] dat = 0, rd, q, d;
    int fails = 0, samples_checked = 0, n;
    // 20 MHz clock
    always #25 clk_i = ~clk_i;
    rbsc_board i_rbsc_board (.clk_i, .full_i(full), .chip_i(chip),
        .strap_i(st), .reset_pin_n_o(pin_n), .test_reset_n_o(trst_n),
        .strap_o(sp));
    rbsc_top #(.HOLD_CYCLES(4), .POR_CYCLES(8)) i_rbsc_top (.clk_i, .rst_i,
        .reset_pin_n_i(pin_n), .test_reset_n_i(trst_n),
        .external_boot_strap_i(sp[0]), .address_width_strap_i(sp[1]),
        .flash_secured_i(sp[2]), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rd), .wb_ack_o(ack), .sys_reset_n_o(sys_n),
        .debug_reset_n_o(dbg_n), .reset_output_pin_n_o(reset_output_pin_n),
        .boot_mode_bit_o(boot), .wide_address_o(wide),
        .flash_secure_mode_o(sec), .reset_pullup_en_o(pr),
        .boot_strap_pullup_en_o(pb), .width_strap_pullup_en_o(pw));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic cycle; ack ends the wait, with no timeout but the watchdog
    task automatic wb(input logic w, input logic [3:0] a,
            input logic [3:0] m, input logic [31:0] v);
        cyc <= 1;
        adr <= a;
        we <= w;
        sel <= m;
        dat <= v;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rd;
        cyc <= 0;
        @(posedge clk_i);
    endtask
    // captured {wide, boot}: secured flash vetoes external boot
    function automatic logic [1:0] cfg(input logic [2:0] v);
        return {v[1], v[0] & !v[2]};
    endfunction
    task automatic complete_run;
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog: the tests need well under 1000 cycles
    initial
    begin
        #400000;
        fails++;
        complete_run;
    end
    // main sequence
    initial
    begin
        void'($urandom(32'h6184));
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        repeat (2) @(posedge clk_i);
        chk({sys_n, pw, pb, pr}, 4'h7);
        repeat (12) @(posedge clk_i);
        wb(0, 4'h0, 4'hf, 0);
        chk(q[2:0], 0);
        // last write has lane 0 off and must be dropped
        for (int i = 0; i < 4; i++)
        begin
            d = $urandom;
            if (i < 3)
                e = d[2:0];
            wb(1, 4'h0, (i < 3) ? 4'h1 : 4'he, d);
            wb(0, 4'h0, 4'hf, 0);
            chk({q[2:0], pw, pb, pr}, {e, ~e});
        end
        // every strap code, then random ones; odd passes reset all
        for (int i = 0; i < 10; i++)
        begin
            s = (i < 8) ? 3'(i) : 3'($urandom);
            full <= i[0];
            chip <= !i[0];
            st <= s;
            // pin needs board, two sync flops and the output flop
            repeat (5 + $urandom % 4) @(posedge clk_i);
            chk({dbg_n, reset_output_pin_n}, {!i[0], 1'b0});
            full <= 0;
            chip <= 0;
            for (n = 0; sys_n !== 1'b1 && n < 50; n++) @(posedge clk_i);
            chk(n > 4 && n < 20, 1);
            chk({wide, boot, sec}, {cfg(s), s[2]});
            wb(0, 4'h4, 4'hf, 0);
            chk(q[4:0], {1'b0, s[2], cfg(s), 1'b1});
            st <= ~s;
            repeat (4) @(posedge clk_i);
            chk({wide, boot, reset_output_pin_n}, {cfg(s), 1'b1});
            wb(0, 4'h8, 4'hf, 0);
            chk(q[2:0], {1'b1, ~s[0], ~s[1]});
        end
        complete_run;
    end
endmodule
